// >>> core/rgbm_pkg.sv
`default_nettype none
package rgbm_pkg;
  // Clock and serial timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned BAUD_RATE     = 9600;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_RATE;
  localparam int unsigned HALF_CYCLES   = BIT_CYCLES / 2;
  localparam int unsigned BAUD_CNT_W    = 13;
  localparam logic [BAUD_CNT_W-1:0] BIT_CNT_LAST =
    BAUD_CNT_W'(BIT_CYCLES - 1);
  localparam logic [BAUD_CNT_W-1:0] HALF_CNT_LAST =
    BAUD_CNT_W'(HALF_CYCLES - 1);
  localparam logic [BAUD_CNT_W-1:0] BAUD_CNT_ZERO = 13'h0000;
  localparam int unsigned DATA_BITS     = 8;
  localparam logic [2:0] LAST_DATA_BIT  = 3'h7;
  localparam logic [2:0] FIRST_DATA_BIT = 3'h0;
  localparam logic       LINE_IDLE      = 1'b1;

  // Colour and timer widths
  localparam int unsigned COLOUR_W      = 8;
  localparam logic [COLOUR_W-1:0] COLOUR_ZERO   = 8'h00;
  localparam logic [COLOUR_W-1:0] PERIOD_VALUE  = 8'hFF;
  localparam logic [COLOUR_W-1:0] TIMER_ZERO    = 8'h00;

  // Received character carrier
  typedef struct packed {
    logic                valid;
    logic [COLOUR_W-1:0] data;
  } rgbm_byte_t;

  // Compare values as one mixed colour
  typedef struct packed {
    logic [COLOUR_W-1:0] red;
    logic [COLOUR_W-1:0] green;
    logic [COLOUR_W-1:0] blue;
  } rgbm_colour_t;

  localparam rgbm_colour_t COLOUR_RESET = '{red: 8'h00, green: 8'h00,
                                            blue: 8'h00};

  typedef enum logic [1:0] {
    RGBM_SLOT_RED,
    RGBM_SLOT_GREEN,
    RGBM_SLOT_BLUE
  } rgbm_slot_t;

  typedef enum logic [1:0] {
    RGBM_RX_IDLE,
    RGBM_RX_START,
    RGBM_RX_DATA,
    RGBM_RX_STOP
  } rgbm_rx_state_t;
endpackage : rgbm_pkg
`default_nettype wire

// >>> core/rgbm_serial_rx.sv
`default_nettype none
module rgbm_serial_rx
  import rgbm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       rx_line,
  output var  rgbm_byte_t rx_byte
);
  rgbm_rx_state_t         state_q, state_d;
  logic [BAUD_CNT_W-1:0]  cnt_q, cnt_d;
  logic [2:0]             bit_q, bit_d;
  logic [COLOUR_W-1:0]    shift_q, shift_d;
  rgbm_byte_t             out_q, out_d;

  // Bit timer step, shared by every counting state
  function automatic logic [BAUD_CNT_W-1:0] cnt_step(
    input logic [BAUD_CNT_W-1:0] cnt
  );
    return cnt + 1'b1;
  endfunction

  // Bit timer and framing; rx_line is already synchronised
  always_comb begin
    state_d       = state_q;
    cnt_d         = cnt_q;
    bit_d         = bit_q;
    shift_d       = shift_q;
    out_d         = out_q;
    out_d.valid   = 1'b0;
    case (state_q)
      RGBM_RX_IDLE: begin
        cnt_d = BAUD_CNT_ZERO;
        if (!rx_line) begin
          state_d = RGBM_RX_START;
        end
      end
      RGBM_RX_START: begin
        // Recheck at mid start bit to reject glitches
        if (cnt_q == HALF_CNT_LAST) begin
          cnt_d = BAUD_CNT_ZERO;
          bit_d = FIRST_DATA_BIT;
          state_d = rx_line ? RGBM_RX_IDLE : RGBM_RX_DATA;
        end else begin
          cnt_d = cnt_step(cnt_q);
        end
      end
      RGBM_RX_DATA: begin
        if (cnt_q == BIT_CNT_LAST) begin
          cnt_d   = BAUD_CNT_ZERO;
          shift_d = {rx_line, shift_q[COLOUR_W-1:1]};
          if (bit_q == LAST_DATA_BIT) begin
            state_d = RGBM_RX_STOP;
          end else begin
            bit_d = bit_q + 1'b1;
          end
        end else begin
          cnt_d = cnt_step(cnt_q);
        end
      end
      RGBM_RX_STOP: begin
        // No parity bit; one stop bit ends the frame
        if (cnt_q == BIT_CNT_LAST) begin
          cnt_d   = BAUD_CNT_ZERO;
          state_d = RGBM_RX_IDLE;
          if (rx_line) begin
            out_d.valid = 1'b1;
            out_d.data  = shift_q;
          end
        end else begin
          cnt_d = cnt_step(cnt_q);
        end
      end
      default: state_d = RGBM_RX_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= RGBM_RX_IDLE;
      cnt_q   <= BAUD_CNT_ZERO;
      bit_q   <= FIRST_DATA_BIT;
      shift_q <= COLOUR_ZERO;
      out_q   <= '{valid: 1'b0, data: COLOUR_ZERO};
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      out_q   <= out_d;
    end
  end

  assign rx_byte = out_q;
endmodule : rgbm_serial_rx
`default_nettype wire

// >>> core/rgbm_mixer.sv
`default_nettype none
// How it works
// - Red is high while the first timer is below the red compare value.
// - Green and blue share the second timer, green on compare 1, blue on 2.
// - The serial input runs at 9600 baud, no parity, one stop bit.
// - Each intensity is an 8-bit unsigned value from 0 to 255.
// - Each output's duty cycle is proportional to its received value.
// - Each group of three bytes applies a new mixed colour.
// - Bytes of a group go to red, then green, then blue.
// - New compare values load at once, with no further command.
module rgbm_mixer
  import rgbm_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic serial_receive_pin,
  output var  logic serial_transmit_pin,
  output var  logic red_pwm_output,
  output var  logic green_pwm_output,
  output var  logic blue_pwm_output
);
  // PWM high while counter sits below compare
  function automatic logic pwm_level(input logic [COLOUR_W-1:0] cnt,
                                     input logic [COLOUR_W-1:0] cmp);
    return cnt < cmp;
  endfunction

  // Timer step: count up to the period value, then wrap to zero
  function automatic logic [COLOUR_W-1:0] tmr_step(
    input logic [COLOUR_W-1:0] cnt
  );
    return (cnt == PERIOD_VALUE) ? TIMER_ZERO : cnt + 1'b1;
  endfunction

  // Two-flop synchroniser on the serial pin
  logic         rx_meta_q;
  logic         rx_sync_q;
  rgbm_byte_t   rx_byte;

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_meta_q <= LINE_IDLE;
      rx_sync_q <= LINE_IDLE;
    end else begin
      rx_meta_q <= serial_receive_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  rgbm_serial_rx u_rx (
    .clk     (clk),
    .reset   (reset),
    .rx_line (rx_sync_q),
    .rx_byte (rx_byte)
  );

  // Byte slot and compare values
  rgbm_slot_t    slot_q, slot_d;
  rgbm_colour_t  cmp_q, cmp_d;

  // Staged group is not kept: each byte loads its compare at once,
  // so a full group completes the new colour on its third byte
  always_comb begin
    slot_d = slot_q;
    cmp_d  = cmp_q;
    if (rx_byte.valid) begin
      case (slot_q)
        RGBM_SLOT_RED: begin
          cmp_d.red = rx_byte.data;
          slot_d    = RGBM_SLOT_GREEN;
        end
        RGBM_SLOT_GREEN: begin
          cmp_d.green = rx_byte.data;
          slot_d      = RGBM_SLOT_BLUE;
        end
        RGBM_SLOT_BLUE: begin
          cmp_d.blue = rx_byte.data;
          slot_d     = RGBM_SLOT_RED;
        end
        default: slot_d = RGBM_SLOT_RED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      slot_q <= RGBM_SLOT_RED;
      cmp_q  <= COLOUR_RESET;
    end else begin
      slot_q <= slot_d;
      cmp_q  <= cmp_d;
    end
  end

  // Two free-running timers, period fixed at full scale
  logic [COLOUR_W-1:0] tmr0_q, tmr0_d;
  logic [COLOUR_W-1:0] tmr1_q, tmr1_d;

  always_comb begin
    tmr0_d = tmr_step(tmr0_q);
    tmr1_d = tmr_step(tmr1_q);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tmr0_q <= TIMER_ZERO;
      tmr1_q <= TIMER_ZERO;
    end else begin
      tmr0_q <= tmr0_d;
      tmr1_q <= tmr1_d;
    end
  end

  // Output flops; duty = compare / (period + 1)
  logic red_d, green_d, blue_d;

  always_comb begin
    red_d   = pwm_level(tmr0_q, cmp_q.red);
    green_d = pwm_level(tmr1_q, cmp_q.green);
    blue_d  = pwm_level(tmr1_q, cmp_q.blue);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      red_pwm_output      <= 1'b0;
      green_pwm_output    <= 1'b0;
      blue_pwm_output     <= 1'b0;
      serial_transmit_pin <= LINE_IDLE;
    end else begin
      red_pwm_output      <= red_d;
      green_pwm_output    <= green_d;
      blue_pwm_output     <= blue_d;
      serial_transmit_pin <= LINE_IDLE; // Idle high; nothing is sent back
    end
  end
endmodule : rgbm_mixer
`default_nettype wire

// >>> tb/rgbm_mixer_properties.sv
`default_nettype none
module rgbm_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_receive_pin,
  input wire logic serial_transmit_pin,
  input wire logic red_pwm_output,
  input wire logic green_pwm_output,
  input wire logic blue_pwm_output
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic  r = red_pwm_output;
  wire logic  g = green_pwm_output;
  wire logic  b = blue_pwm_output;
  logic [1:0] rn_q, gn_q, bn_q;
  logic [7:0] rgap_q, ggap_q;
  // Cycles since last rise; 8 bits wrap each period, so zero duty is fine.
  // A compare raised mid-period gives one early rise, so gaps are judged
  // from the third rise on; raising an already lit channel is not covered
  always_ff @(posedge clk) begin
    rn_q   <= reset ? 2'h0 :
              (($rose(r) && rn_q != 2'h2) ? rn_q + 2'h1 : rn_q);
    gn_q   <= reset ? 2'h0 :
              (($rose(g) && gn_q != 2'h2) ? gn_q + 2'h1 : gn_q);
    bn_q   <= reset ? 2'h0 :
              (($rose(b) && bn_q != 2'h2) ? bn_q + 2'h1 : bn_q);
    rgap_q <= $rose(r) ? 8'h00 : rgap_q + 8'h01;
    ggap_q <= $rose(g) ? 8'h00 : ggap_q + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_tx_idle: assert property (serial_transmit_pin)
    else $error("tx not idle");
  a_dark_reset: assert property ($fell(reset) |-> !(r || g || b))
    else $error("lit after reset");
  a_red_high: assert property ($rose(r) |-> ##[1:255] !r)
    else $error("red stuck");
  a_green_high: assert property ($rose(g) |-> ##[1:255] !g)
    else $error("green stuck");
  a_blue_high: assert property ($rose(b) |-> ##[1:255] !b)
    else $error("blue stuck");
  a_red_gap: assert property ($rose(r) && rn_q == 2'h2
    |-> rgap_q == 8'hFF)
    else $error("red period");
  a_green_gap: assert property ($rose(g) && gn_q == 2'h2
    |-> ggap_q == 8'hFF)
    else $error("green period");
  a_blue_gap: assert property ($rose(b) && bn_q == 2'h2 && gn_q == 2'h2
    |-> ggap_q == 8'hFF)
    else $error("blue not on shared timer");
  c_frame: cover property ($fell(serial_receive_pin));
  c_red: cover property ($rose(r));
  c_green: cover property ($rose(g));
  c_blue: cover property ($rose(b));
endmodule // rgbm_chk

bind rgbm_mixer rgbm_chk chk_u (.clk, .reset, .serial_receive_pin,
  .serial_transmit_pin, .red_pwm_output, .green_pwm_output,
  .blue_pwm_output);
`default_nettype wire

// >>> tb/rgbm_host.sv
`default_nettype none
module rgbm_host
  import rgbm_pkg::*;
(
  input  wire logic clk,
  output var  logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial line = 1'b1;
  // Low start, LSB first, high stop; line rests high after.
  // One byte per call, so a lone colour byte is just a single call
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask
endmodule // rgbm_host
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, rx, tx, r, g, b;
  int   fails, compares;
  rgbm_host host_u (.clk(clk), .line(rx));
  rgbm_mixer dut_u (.clk(clk), .reset(reset), .serial_receive_pin(rx),
    .serial_transmit_pin(tx), .red_pwm_output(r),
    .green_pwm_output(g), .blue_pwm_output(b));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // High count over one whole period equals the compare value
  task automatic duty(input logic [8:0] er, eg, eb);
    logic [8:0] nr, ng, nb;
    {nr, ng, nb} = '0;
    repeat (300) @(posedge clk);
    repeat (256) begin
      @(posedge clk);
      #1;
      {nr, ng, nb} = {nr + 9'(r), ng + 9'(g), nb + 9'(b)};
    end
    chk(nr, er);
    chk(ng, eg);
    chk(nb, eb);
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Dark outputs and idle transmitter out of reset
  task automatic after_reset;
    duty(9'h000, 9'h000, 9'h000);
    chk({8'h00, tx}, 9'h001);
  endtask
  // Asymmetric bytes 01 and C0 expose bit order; each byte applies at once
  task automatic byte_group;
    host_u.send(8'h01);
    duty(9'h001, 9'h000, 9'h000);
    host_u.send(8'hC0);
    duty(9'h001, 9'h0C0, 9'h000);
    host_u.send(8'hFF);
    duty(9'h001, 9'h0C0, 9'h0FF);
  endtask
  initial begin
    reset = 1'b1;
    fails = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    after_reset();
    byte_group();
    conclude();
  end
  // Hang guard
  initial begin
    repeat (140000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
